// [lbl_apb_slave.sv]
/*
  APB slave holding the ladder and regulator control words.
  Assumes a zero-wait APB master on the same clock as the block.
*/
`timescale 1ns/1ps
`include "lbl_regs.svh"

module lbl_apb_slave
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [15:0] status_in,
  output logic      [31:0] prdata_out,
  output logic             pslverr_out,
  output logic      [15:0] ref_word_out,
  output logic      [15:0] reg_word_out
);

  logic [15:0] ref_reg;
  logic [15:0] ref_next;
  logic [15:0] regu_reg;
  logic [15:0] regu_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        err_reg;
  logic        err_next;
  logic        setup;
  logic        access;
  logic        hit;

  always_comb
  begin
    setup      = psel_in && !penable_in;
    access     = psel_in && penable_in;
    hit        = (paddr_in == `LBL_OFF_REF) || (paddr_in == `LBL_OFF_REG) ||
                 (paddr_in == `LBL_OFF_STAT);
    ref_next   = ref_reg;
    regu_next  = regu_reg;
    rdata_next = rdata_reg;
    err_next   = 1'b0;
    if (setup)
    begin
      err_next = !hit;
      if (!pwrite_in)
      begin
        case (paddr_in)
          `LBL_OFF_REF:  rdata_next = {16'h0000, ref_reg};
          `LBL_OFF_REG:  rdata_next = {16'h0000, regu_reg};
          `LBL_OFF_STAT: rdata_next = {16'h0000, status_in};
          default:       rdata_next = 32'h0000_0000;
        endcase
      end
    end
    // Writes land at the access edge, where the master sees ready high.
    if (access && pwrite_in)
    begin
      if (paddr_in == `LBL_OFF_REF)
      begin
        ref_next = pwdata_in[15:0] & `LBL_REF_WMASK;
      end
      else if (paddr_in == `LBL_OFF_REG)
      begin
        regu_next = pwdata_in[15:0] & `LBL_REG_WMASK;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      ref_reg   <= `LBL_REF_RESET;
      regu_reg  <= `LBL_REG_RESET;
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end
    else
    begin
      ref_reg   <= ref_next;
      regu_reg  <= regu_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  assign prdata_out   = rdata_reg;
  assign pslverr_out  = err_reg;
  assign ref_word_out = ref_reg;
  assign reg_word_out = regu_reg;

endmodule

// [lbl_bias_ctrl.sv]
/*
  Bias reference ladder power control: register access, A/B interval timing, ladder
  power, pin routing and regulator controls.
  Assumes segment clock ticks and segment change strobes are pins from another domain.
*/
`timescale 1ns/1ps
`include "lbl_regs.svh"

////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: Reference enable bit turns internal reference on, tied to contrast circuit.
// R2: Without internal reference the contrast circuit is off; bias comes externally.
// R3: Module inactive forces the reference ladder off whatever power settings say.
// R4: Disabling reference disconnects all three ladders together.
// R5: Three-bit contrast code picks ladder resistance in sevenths; zero shorts it.
// R6: Three pin enables route bias levels 3, 2, 1 to their external pins.
// R7: Interval A power code: high, medium, low or powered down.
// R8: Interval B power code uses the same encoding.
// R9: Interval A high power turns on medium and high ladders together.
// R10: Interval A starts at a waveform transition; B covers the remainder.
// R11: Each segment time holds 32 counts; intervals are measured in them.
// R12: Waveform type 0: A for N counts, then B for 16 minus N.
// R13: Waveform type 1: A for N counts, then B for 32 minus N.
// R14: Length code zero keeps power mode B all segment time.
// R15: Supply select feeds the internal ladder from main or core supply.
// R16: Regulator enabled by clock select; charge pump by its own bit.
// R17: While regulator runs, type bit and level field are driven out.
// R18: Clock select code 00 disables the regulator.
// R19: Interval counter restarts at zero on every segment or common change.
module lbl_bias_ctrl
(
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [11:0]       paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              module_active_flag_in,
  input  wire logic              waveform_type_select_in,
  input  wire logic              ladder_supply_select_in,
  input  wire logic              seg_tick_in,
  input  wire logic              seg_change_in,
  output lbl_pkg::lbl_ladder_t   ladder_out,
  output lbl_pkg::lbl_route_t    route_out,
  output lbl_pkg::lbl_regu_t     regu_out,
  output logic                   interval_a_out
);

  logic [15:0]          ref_word;
  logic [15:0]          reg_word;
  logic [15:0]          status_word;
  logic [1:0]           act_sync_reg;
  logic [1:0]           wft_sync_reg;
  logic [1:0]           sup_sync_reg;
  logic [2:0]           tick_sync_reg;
  logic [2:0]           chg_sync_reg;
  logic [1:0]           act_sync_next;
  logic [1:0]           wft_sync_next;
  logic [1:0]           sup_sync_next;
  logic [2:0]           tick_sync_next;
  logic [2:0]           chg_sync_next;
  logic                 tick_pulse;
  logic                 chg_pulse;
  logic                 active;
  logic                 ref_enabled;
  logic [5:0]           count_reg;
  logic [5:0]           count_next;
  lbl_pkg::lbl_phase_t  phase_reg;
  lbl_pkg::lbl_phase_t  phase_next;
  logic [1:0]           power_code;
  lbl_pkg::lbl_ladder_t ladder_dec;
  lbl_pkg::lbl_ladder_t ladder_reg;
  lbl_pkg::lbl_route_t  route_next;
  lbl_pkg::lbl_route_t  route_reg;
  lbl_pkg::lbl_regu_t   regu_next;
  lbl_pkg::lbl_regu_t   regu_reg;
  logic                 pready_reg;
  logic                 pready_next;
  logic                 interval_a_reg;
  logic                 interval_a_next;

  // Length of the part of a segment time the interval timing covers.
  function automatic logic [5:0] span_of(input logic waveform_type_select);
    span_of = waveform_type_select ? `LBL_SEG_COUNTS : `LBL_TYPEA_COUNTS;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////
  // Register access.

  lbl_apb_slave u_apb
  (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .psel_in      (psel_in),
    .penable_in   (penable_in),
    .pwrite_in    (pwrite_in),
    .paddr_in     (paddr_in),
    .pwdata_in    (pwdata_in),
    .status_in    (status_word),
    .prdata_out   (prdata_out),
    .pslverr_out  (pslverr_out),
    .ref_word_out (ref_word),
    .reg_word_out (reg_word)
  );

  // Ready is registered from the setup cycle, so every access ends in its first cycle.
  always_comb
  begin
    status_word = {8'h00, count_reg[4:0], interval_a_out, active, ref_enabled};
    pready_next = psel_in && !penable_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      pready_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= pready_next;
    end
  end

  assign pready_out = pready_reg;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Synchronisers; bit 0 is read only by bit 1.

  always_comb
  begin
    act_sync_next  = {act_sync_reg[0], module_active_flag_in};
    wft_sync_next  = {wft_sync_reg[0], waveform_type_select_in};
    sup_sync_next  = {sup_sync_reg[0], ladder_supply_select_in};
    tick_sync_next = {tick_sync_reg[1:0], seg_tick_in};
    chg_sync_next  = {chg_sync_reg[1:0], seg_change_in};
    tick_pulse     = tick_sync_reg[1] && !tick_sync_reg[2];
    chg_pulse      = chg_sync_reg[1] && !chg_sync_reg[2];
    active         = act_sync_reg[1];
    ref_enabled    = ref_word[`LBL_IRE_BIT] && active; // R1 R3
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      act_sync_reg  <= 2'b00;
      wft_sync_reg  <= 2'b00;
      sup_sync_reg  <= 2'b00;
      tick_sync_reg <= 3'b000;
      chg_sync_reg  <= 3'b000;
    end
    else
    begin
      act_sync_reg  <= act_sync_next;
      wft_sync_reg  <= wft_sync_next;
      sup_sync_reg  <= sup_sync_next;
      tick_sync_reg <= tick_sync_next;
      chg_sync_reg  <= chg_sync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Interval A/B timing in segment clock counts.

  always_comb
  begin
    count_next = count_reg;
    phase_next = phase_reg;
    if (chg_pulse)
    begin
      count_next = 6'd0; // R19
      phase_next = (ref_word[`LBL_AT_HI:`LBL_AT_LO] != 3'b000) ? // R10 R14
                   lbl_pkg::LBL_PHASE_A : lbl_pkg::LBL_PHASE_B;
    end
    else if (tick_pulse)
    begin
      if ((count_reg + 6'd1) < span_of(wft_sync_reg[1])) // R11 R12 R13
      begin
        count_next = count_reg + 6'd1;
      end
      case (phase_reg)
        lbl_pkg::LBL_PHASE_A:
        begin
          if ((count_reg + 6'd1) >= {3'b000, ref_word[`LBL_AT_HI:`LBL_AT_LO]}) // R12 R13
          begin
            phase_next = lbl_pkg::LBL_PHASE_B;
          end
        end
        lbl_pkg::LBL_PHASE_B: phase_next = lbl_pkg::LBL_PHASE_B; // R12 R13
        default:              phase_next = lbl_pkg::LBL_PHASE_B;
      endcase
    end
    interval_a_next = (phase_next == lbl_pkg::LBL_PHASE_A);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      count_reg      <= 6'd0;
      phase_reg      <= lbl_pkg::LBL_PHASE_B;
      interval_a_reg <= 1'b0;
    end
    else
    begin
      count_reg      <= count_next;
      phase_reg      <= phase_next;
      interval_a_reg <= interval_a_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Ladder power, routing and regulator outputs.

  always_comb
  begin
    power_code = (phase_reg == lbl_pkg::LBL_PHASE_A) ?
                 ref_word[`LBL_AP_HI:`LBL_AP_LO] : ref_word[`LBL_BP_HI:`LBL_BP_LO]; // R7 R8
  end

  lbl_ladder_decode u_dec
  (
    .code_in    (power_code),
    .allow_in   (ref_enabled), // R3 R4
    .ladder_out (ladder_dec)
  );

  always_comb
  begin
    route_next.ref_on       = ref_enabled; // R1
    route_next.contrast_on  = ref_enabled; // R2
    route_next.contrast_tap = ref_word[`LBL_CST_HI:`LBL_CST_LO]; // R5
    route_next.pin_enable   = {ref_word[`LBL_PE3_BIT], ref_word[`LBL_PE2_BIT],
                               ref_word[`LBL_PE1_BIT]}; // R6
    route_next.supply_core  = sup_sync_reg[1] && ref_enabled; // R15
    regu_next.reg_clock     = reg_word[`LBL_CKS_HI:`LBL_CKS_LO];
    regu_next.reg_enable    = (reg_word[`LBL_CKS_HI:`LBL_CKS_LO] != `LBL_CKS_OFF); // R16 R18
    regu_next.pump_enable   = reg_word[`LBL_CHARGE_PUMP_ENABLE_BIT]; // R16
    regu_next.third_type    = regu_next.reg_enable && reg_word[`LBL_MODE_BIT]; // R17
    regu_next.level         = reg_word[`LBL_LVL_HI:`LBL_LVL_LO]; // R17
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      ladder_reg <= '0;
      route_reg  <= '0;
      regu_reg   <= '0;
    end
    else
    begin
      ladder_reg <= ladder_dec;
      route_reg  <= route_next;
      regu_reg   <= regu_next;
    end
  end

  assign ladder_out     = ladder_reg;
  assign route_out      = route_reg;
  assign regu_out       = regu_reg;
  assign interval_a_out = interval_a_reg;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_inactive_ladder_off: assert property (@(posedge clk_in) disable iff (!rstn_in) // R3
    !act_sync_reg[1] |=> ladder_out == '0)
    else $error("ladder powered while module inactive");

  a_ref_off_all: assert property (@(posedge clk_in) disable iff (!rstn_in) // R4
    !ref_word[`LBL_IRE_BIT] |=> (ladder_out == '0) && !route_out.ref_on)
    else $error("ladders not all off with reference disabled");

  a_high_both_on: assert property (@(posedge clk_in) disable iff (!rstn_in) // R9
    (ref_enabled && interval_a_out && ref_word[`LBL_AP_HI:`LBL_AP_LO] == `LBL_PWR_HIGH)
    |=> ladder_out.med_on && ladder_out.high_on)
    else $error("high power did not enable both ladders");

  a_zero_len_b: assert property (@(posedge clk_in) disable iff (!rstn_in) // R14
    (chg_pulse && ref_word[`LBL_AT_HI:`LBL_AT_LO] == 3'b000) |=> !interval_a_out)
    else $error("interval A entered with zero length");

  a_change_restart: assert property (@(posedge clk_in) disable iff (!rstn_in) // R19
    chg_pulse |=> count_reg == 6'd0)
    else $error("counter not restarted on change");

  a_count_bound: assert property (@(posedge clk_in) disable iff (!rstn_in) // R11
    count_reg < `LBL_SEG_COUNTS)
    else $error("count left the segment time");

  a_a_ends_at_n: assert property (@(posedge clk_in) disable iff (!rstn_in) // R12
    (interval_a_out && tick_pulse && !chg_pulse &&
     (count_reg + 6'd1) >= {3'b000, ref_word[`LBL_AT_HI:`LBL_AT_LO]}) |=> !interval_a_out)
    else $error("interval A overran its length");

  a_reg_disable: assert property (@(posedge clk_in) disable iff (!rstn_in) // R18
    (reg_word[`LBL_CKS_HI:`LBL_CKS_LO] == `LBL_CKS_OFF) |=> !regu_out.reg_enable)
    else $error("regulator enabled with clock select 00");

  a_span_used: assert property (@(posedge clk_in) disable iff (!rstn_in) // R13
    (tick_pulse && !chg_pulse && (count_reg + 6'd1) >= span_of(wft_sync_reg[1]))
    |=> $stable(count_reg))
    else $error("count ran past the segment span");

endmodule

// [lbl_ladder_decode.sv]
/*
  Turns a two-bit power code into the set of ladders that must be powered.
  Assumes a purely combinational use inside the control block.
*/
`timescale 1ns/1ps
`include "lbl_regs.svh"

module lbl_ladder_decode
(
  input  wire logic [1:0]          code_in,
  input  wire logic                allow_in,
  output lbl_pkg::lbl_ladder_t     ladder_out
);

  always_comb
  begin
    ladder_out = '0;
    if (allow_in)
    begin
      case (code_in)
        `LBL_PWR_LOW:  ladder_out.low_on = 1'b1;
        `LBL_PWR_MED:  ladder_out.med_on = 1'b1;
        `LBL_PWR_HIGH:
        begin
          ladder_out.med_on  = 1'b1; // R9
          ladder_out.high_on = 1'b1; // R9
        end
        default:       ladder_out = '0; // R7 R8
      endcase
    end
  end

endmodule

// [lbl_panel_model.sv]
/*
  Far side of the bias ladder block: makes segment change and tick strobes, watches the ladders.
  Assumes one clock shared with the block and a go pulse from the bench.
*/
`timescale 1ns/1ps

module lbl_panel_model
(
  input  wire logic           clk_in,
  input  wire logic           rstn_in,
  input  wire logic           go_in,
  input  wire logic [5:0]     ticks_in,
  input  wire logic           interval_a_in,
  input  lbl_pkg::lbl_ladder_t ladder_in,
  output logic                seg_tick_out,
  output logic                seg_change_out,
  output logic                busy_out,
  output logic [8:0]          a_cycles_out,
  output lbl_pkg::lbl_ladder_t ladder_a_out,
  output lbl_pkg::lbl_ladder_t ladder_b_out
);
  logic [8:0] step_reg;
  logic [8:0] end_step;

  assign end_step = {ticks_in, 3'b000} + 9'h010;

  // Change strobe opens the segment, then one tick every eight clocks; both idle low outside.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      busy_out       <= 1'b0;
      step_reg       <= '0;
      seg_tick_out   <= 1'b0;
      seg_change_out <= 1'b0;
      a_cycles_out   <= '0;
      // All ones marks a ladder value that was never captured.
      ladder_a_out   <= '1;
      ladder_b_out   <= '1;
    end
    else if (go_in && !busy_out)
    begin
      busy_out     <= 1'b1;
      step_reg     <= '0;
      a_cycles_out <= '0;
      ladder_a_out <= '1;
      ladder_b_out <= '1;
    end
    else if (busy_out)
    begin
      step_reg       <= step_reg + 9'h001;
      seg_change_out <= (step_reg < 9'h004);
      seg_tick_out   <= (step_reg >= 9'h008) && !step_reg[2] && (step_reg < end_step - 9'h008);
      a_cycles_out   <= a_cycles_out + {8'h00, interval_a_in};
      if (interval_a_in && step_reg > 9'h006)
        ladder_a_out <= ladder_in;
      if (!interval_a_in && step_reg == end_step - 9'h004)
        ladder_b_out <= ladder_in;
      if (step_reg == end_step)
        busy_out <= 1'b0;
    end
  end
endmodule

// [lbl_pkg.sv]
/*
  Types shared by the bias ladder control block.
  Assumes lbl_regs.svh is on the include path.
*/
`include "lbl_regs.svh"

package lbl_pkg;

  typedef enum logic [1:0] {
    LBL_PHASE_A = 2'b01,
    LBL_PHASE_B = 2'b10
  } lbl_phase_t;

  typedef struct packed {
    logic       low_on;
    logic       med_on;
    logic       high_on;
  } lbl_ladder_t;

  typedef struct packed {
    logic       ref_on;
    logic       contrast_on;
    logic [2:0] contrast_tap;
    logic [2:0] pin_enable;
    logic       supply_core;
  } lbl_route_t;

  typedef struct packed {
    logic       reg_enable;
    logic [1:0] reg_clock;
    logic       pump_enable;
    logic       third_type;
    logic [2:0] level;
  } lbl_regu_t;

endpackage

// [lbl_regs.svh]
/*
  Register offsets, field positions and reset values of the bias ladder control block.
  Assumes inclusion by its bare name from the package and design files.
*/
`ifndef LBL_REGS_SVH
`define LBL_REGS_SVH

`define LBL_OFF_REF          12'h000
`define LBL_OFF_REG          12'h004
`define LBL_OFF_STAT         12'h008

`define LBL_REF_RESET        16'h0000
`define LBL_REG_RESET        16'h003C
`define LBL_REF_WMASK        16'hBFF7
`define LBL_REG_WMASK        16'h803F

`define LBL_IRE_BIT          15
`define LBL_CST_HI           13
`define LBL_CST_LO           11
`define LBL_PE3_BIT          10
`define LBL_PE2_BIT          9
`define LBL_PE1_BIT          8
`define LBL_AP_HI            7
`define LBL_AP_LO            6
`define LBL_BP_HI            5
`define LBL_BP_LO            4
`define LBL_AT_HI            2
`define LBL_AT_LO            0

`define LBL_CHARGE_PUMP_ENABLE_BIT         15
`define LBL_LVL_HI           5
`define LBL_LVL_LO           3
`define LBL_MODE_BIT         2
`define LBL_CKS_HI           1
`define LBL_CKS_LO           0

`define LBL_SEG_COUNTS       6'd32
`define LBL_TYPEA_COUNTS     6'd16
`define LBL_PWR_OFF          2'b00
`define LBL_PWR_LOW          2'b01
`define LBL_PWR_MED          2'b10
`define LBL_PWR_HIGH         2'b11
`define LBL_CKS_OFF          2'b00

`endif

// [lcd_bias_ladder_power_control_tb.sv]
/*
  Self-checking bench for the bias ladder control block, driving it over APB and from the panel model.
  Assumes the design package and register header are compiled first.
*/
`timescale 1ns/1ps

module lcd_bias_ladder_power_control_tb;
  logic                 clk_in, rstn_in, psel, penable, pwrite, act, waveform_type_select, sup, go;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 pready, pslverr, err, tick, chg, a_out, busy;
  logic [5:0]           ticks;
  logic [8:0]           a_cyc;
  lbl_pkg::lbl_ladder_t ladder, lad_a, lad_b;
  lbl_pkg::lbl_route_t  route;
  lbl_pkg::lbl_regu_t   regu;
  int                   err_count, num_checks;

  lbl_bias_ctrl dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .module_active_flag_in(act),
    .waveform_type_select_in(waveform_type_select), .ladder_supply_select_in(sup), .seg_tick_in(tick),
    .seg_change_in(chg), .ladder_out(ladder), .route_out(route), .regu_out(regu),
    .interval_a_out(a_out));

  lbl_panel_model panel_u (.clk_in(clk_in), .rstn_in(rstn_in), .go_in(go), .ticks_in(ticks),
    .interval_a_in(a_out), .ladder_in(ladder), .seg_tick_out(tick), .seg_change_out(chg),
    .busy_out(busy), .a_cycles_out(a_cyc), .ladder_a_out(lad_a), .ladder_b_out(lad_b));

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
    begin
      err_count++;
      $display("MISMATCH t=%0t apb ready never came", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic seg(input logic w);
    int k;
    waveform_type_select <= w;
    ticks <= w ? 6'd32 : 6'd16;
    repeat (6) @(posedge clk_in);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk_in);
      k++;
    end while (busy !== 1'b0 && k < 1000);
    if (busy !== 1'b0)
    begin
      err_count++;
      $display("MISMATCH t=%0t segment never ended", $time);
    end
  endtask

  function automatic logic [2:0] lad(input logic [1:0] c);
    return (c == 2'b01) ? 3'b100 : (c == 2'b10) ? 3'b010 : (c == 2'b11) ? 3'b011 : 3'b000;
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(0, 12'h000, 0); chk(rd, 32'h0000_0000, "ref reset");
    apb(0, 12'h004, 0); chk(rd, 32'h0000_003C, "reg reset");
    chk(regu[7:4], 4'h0, "regulator off at reset");
    apb(1, 12'h000, 32'hFFFF_FFFF); apb(0, 12'h000, 0); chk(rd, 32'h0000_BFF7, "ref mask");
    apb(1, 12'h004, 32'hFFFF_FFFF); apb(0, 12'h004, 0); chk(rd, 32'h0000_803F, "reg mask");
    apb(0, 12'h00C, 0); chk(rd, 32'h0000_0000, "unmapped read data");
    chk(err, 1'b1, "unmapped read error");
    apb(1, 12'h00C, 32'h0000_FFFF); chk(err, 1, "unmapped write");
    $display("test registers done");
  endtask

  task automatic t_route();
    for (int c = 0; c < 8; c++)
    begin
      sup <= c[0];
      apb(1, 12'h000, 32'h0000_8000 | (c << 11) | (c << 8));
      repeat (5) @(posedge clk_in);
      chk(route, {2'b11, c[2:0], c[2:0], c[0]}, "route on");
    end
    apb(1, 12'h000, 32'h0000_2D00);
    repeat (5) @(posedge clk_in);
    chk(route[8:7], 2'b00, "route off");
    $display("test route done");
  endtask

  task automatic t_regu();
    for (int c = 0; c < 4; c++)
    begin
      apb(1, 12'h004, 32'h0000_8000 | ((2 * c + 1) << 3) | (c[0] << 2) | c);
      repeat (3) @(posedge clk_in);
      chk(regu[7:4], {c != 0, c[1:0], 1'b1}, "regulator enable");
      if (c != 0)
        chk(regu[3:0], {c[0], 3'(2 * c + 1)}, "regulator type level");
    end
    apb(1, 12'h004, 32'h0000_0001);
    repeat (3) @(posedge clk_in);
    chk(regu[4], 1'b0, "pump off");
    $display("test regulator done");
  endtask

  task automatic t_interval();
    int n[4] = '{0, 1, 4, 7};
    for (int w = 0; w < 2; w++)
      for (int i = 0; i < 4; i++)
      begin
        apb(1, 12'h000, 32'h0000_80D0 | n[i]);
        seg(w[0]);
        chk((a_cyc + 4) / 8, n[i], "interval a length");
        if (n[i] != 0)
          chk(lad_a, 3'b011, "high power ladders");
        else
          chk(lad_a, 3'b111, "no interval a capture");
        chk(lad_b, 3'b100, "interval b ladder");
        apb(0, 12'h008, 0);
        chk(rd, {24'h00_0000, (w != 0) ? 5'd31 : 5'd15, 3'b011}, "span count");
      end
    $display("test interval done");
  endtask

  task automatic t_power();
    for (int ap = 0; ap < 4; ap++)
    begin
      apb(1, 12'h000, 32'h0000_8003 | (ap << 6) | ((3 - ap) << 4));
      seg(1'b0);
      chk(lad_a, lad(ap[1:0]), "a power code");
      chk(lad_b, lad(2'(3 - ap)), "b power code");
    end
    act <= 1'b0;
    apb(1, 12'h000, 32'h0000_80F3);
    seg(1'b0);
    chk({lad_a, lad_b}, 6'h00, "inactive ladders off");
    act <= 1'b1;
    apb(1, 12'h000, 32'h0000_00F3);
    seg(1'b0);
    chk({lad_a, lad_b}, 6'h00, "reference off ladders off");
    $display("test power done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_count = 0; num_checks = 0;
    rstn_in = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    act = 1'b1; waveform_type_select = 1'b0; sup = 1'b0; go = 1'b0; ticks = 6'd16;
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_regs();
    t_route();
    t_regu();
    t_interval();
    t_power();
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
endmodule
